// [verilog/pac_top.sv]
// phase adjust control: register slave, collection window, search engine, frame measurement
`default_nettype none
module pac_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // axi4-lite slave
    input wire logic [8:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [8:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // video timing and pixels
    input wire logic line_sync_output,
    input wire logic frame_sync,
    input wire logic pixel_valid,
    input wire logic [9:0] pix_red,
    input wire logic [9:0] pix_green,
    input wire logic [9:0] pix_blue,
    input wire logic xtal_tick,
    // results
    output logic [5:0] sample_phase,
    output logic phase_engine_busy,
    output logic [11:0] active_start,
    output logic [11:0] active_width,
    output logic [11:0] frame_period,
    output logic [6:0] vsync_width,
    output logic [3:0] visible_lines_high,
    output logic [7:0] visible_lines_low
);
    logic aw_full, w_full, w_lane0, wr_fire, wr_hit, cmd_wr, rd_hit, eng_rst;
    logic [6:0] aw_idx, rd_idx;
    logic [31:0] w_data;
    logic [7:0] rd_byte;
    logic [2:0] cmd_code;
    logic [1:0] meas_cfg;
    logic [2:0] lines_skip_before_frame_edge, lines_skip_after_frame_edge;
    logic [7:0] pixels_skip_after_line_edge, pixels_skip_before_line_edge;
    logic [6:0] opt;
    pac_pkg::pac_state_t state;

    // write channel: address and data taken in either order
    assign wr_fire = aw_full && w_full && !s_axi_bvalid;
    assign wr_hit = aw_idx >= pac_pkg::IDX_VIS_HI && aw_idx <= pac_pkg::IDX_OPT;
    assign cmd_code = w_data[2:0];
    assign cmd_wr = wr_fire && w_lane0 && aw_idx == pac_pkg::IDX_CMD;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_idx <= '0;
            w_data <= '0;
            w_lane0 <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pac_pkg::RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? pac_pkg::RESP_OKAY : pac_pkg::RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_full <= 1'b1;
                    aw_idx <= s_axi_awaddr[8:2];
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_full <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_lane0 <= s_axi_wstrb[0];
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
            s_axi_awready <= wr_fire || !(aw_full || (s_axi_awvalid && s_axi_awready));
            s_axi_wready <= wr_fire || !(w_full || (s_axi_wvalid && s_axi_wready));
        end
    end

    // register file
    always_ff @(posedge core_clk) begin
        if (srst) begin
            visible_lines_high <= pac_pkg::RST_VIS_HI;
            visible_lines_low <= pac_pkg::RST_VIS_LO;
            meas_cfg <= pac_pkg::RST_MEAS;
            lines_skip_before_frame_edge <= pac_pkg::RST_SKIP_BEFORE;
            lines_skip_after_frame_edge <= pac_pkg::RST_SKIP_AFTER;
            pixels_skip_after_line_edge <= pac_pkg::RST_HMASK1;
            pixels_skip_before_line_edge <= pac_pkg::RST_HMASK2;
            opt <= pac_pkg::RST_OPT;
        end else if (wr_fire && w_lane0) begin
            case (aw_idx)
                pac_pkg::IDX_VIS_HI: visible_lines_high <= w_data[3:0];
                pac_pkg::IDX_VIS_LO: visible_lines_low <= w_data[7:0];
                pac_pkg::IDX_MEAS: meas_cfg <= w_data[1:0];
                pac_pkg::IDX_VMASK: begin
                    lines_skip_before_frame_edge <= w_data[2:0];
                    lines_skip_after_frame_edge <= w_data[6:4];
                end
                pac_pkg::IDX_HMASK1: pixels_skip_after_line_edge <= w_data[7:0];
                pac_pkg::IDX_HMASK2: pixels_skip_before_line_edge <= w_data[7:0];
                pac_pkg::IDX_OPT: opt <= w_data[6:0];
                default: opt <= opt;
            endcase
        end
    end

    // read channel
    assign rd_idx = s_axi_araddr[8:2];
    assign rd_hit = rd_idx >= pac_pkg::IDX_VIS_HI && rd_idx <= pac_pkg::IDX_OPT;
    always_comb begin
        rd_byte = 8'h00;
        case (rd_idx)
            pac_pkg::IDX_VIS_HI: rd_byte = {4'h0, visible_lines_high};
            pac_pkg::IDX_VIS_LO: rd_byte = visible_lines_low;
            pac_pkg::IDX_MEAS: rd_byte = {6'h00, meas_cfg};
            pac_pkg::IDX_STATUS: rd_byte = {phase_engine_busy, 7'h00};
            pac_pkg::IDX_VMASK: begin
                rd_byte = {1'b0, lines_skip_after_frame_edge, 1'b0, lines_skip_before_frame_edge};
            end
            pac_pkg::IDX_HMASK1: rd_byte = pixels_skip_after_line_edge;
            pac_pkg::IDX_HMASK2: rd_byte = pixels_skip_before_line_edge;
            pac_pkg::IDX_OPT: rd_byte = {1'b0, opt};
            default: rd_byte = 8'h00;
        endcase
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= pac_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? pac_pkg::RESP_OKAY : pac_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // collection window
    logic fs_d, frame_edge, coll, coll_d, in_h, in_v, active_px;
    logic [11:0] pix_cnt, line_len, line_cnt, frame_lines;
    logic [9:0] prev_r, prev_g, prev_b;
    logic [11:0] pix_metric;
    assign eng_rst = srst || opt[pac_pkg::BIT_SOFT_RST];
    assign frame_edge = frame_sync && !fs_d;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            fs_d <= 1'b0;
        end else begin
            fs_d <= frame_sync;
        end
    end
    always_ff @(posedge core_clk) begin
        if (eng_rst) begin
            pix_cnt <= '0;
            line_len <= '0;
            line_cnt <= '0;
            frame_lines <= '0;
        end else begin
            if (line_sync_output) begin
                line_len <= pix_cnt;
                pix_cnt <= '0;
            end else if (pixel_valid && pix_cnt != 12'hFFF) begin
                pix_cnt <= pix_cnt + 12'h001;
            end
            if (frame_edge) begin
                frame_lines <= line_cnt + 12'h001;
                line_cnt <= '0;
            end else if (line_sync_output && line_cnt != 12'hFFF) begin
                line_cnt <= line_cnt + 12'h001;
            end
        end
    end
    assign in_h = {1'b0, pix_cnt} >= {4'h0, pixels_skip_after_line_edge, 1'b0}
        && {1'b0, pix_cnt} + {4'h0, pixels_skip_before_line_edge, 1'b0} < {1'b0, line_len};
    assign in_v = line_cnt >= {6'h00, pac_pkg::pac_lines_after(lines_skip_after_frame_edge)}
        && {1'b0, line_cnt} + {7'h00, pac_pkg::pac_lines_before(lines_skip_before_frame_edge)}
        < {1'b0, frame_lines};
    assign coll = pixel_valid && in_h && in_v;

    function automatic logic [9:0] absd(input logic [9:0] a, input logic [9:0] b);
        absd = a > b ? a - b : b - a;
    endfunction
    // transition energy over enabled channels
    assign pix_metric = (opt[pac_pkg::BIT_BLUE_OFF] ? 12'h000 : {2'h0, absd(pix_blue, prev_b)})
        + (opt[pac_pkg::BIT_GREEN_OFF] ? 12'h000 : {2'h0, absd(pix_green, prev_g)})
        + (opt[pac_pkg::BIT_RED_OFF] ? 12'h000 : {2'h0, absd(pix_red, prev_r)});
    assign active_px = (!opt[pac_pkg::BIT_BLUE_OFF] && pix_blue > pac_pkg::ACT_LEVEL)
        || (!opt[pac_pkg::BIT_GREEN_OFF] && pix_green > pac_pkg::ACT_LEVEL)
        || (!opt[pac_pkg::BIT_RED_OFF] && pix_red > pac_pkg::ACT_LEVEL);
    always_ff @(posedge core_clk) begin
        if (eng_rst) begin
            coll_d <= 1'b0;
            prev_r <= '0;
            prev_g <= '0;
            prev_b <= '0;
        end else begin
            if (pixel_valid || line_sync_output) begin
                coll_d <= coll && !line_sync_output;
            end
            if (pixel_valid) begin
                prev_r <= pix_red;
                prev_g <= pix_green;
                prev_b <= pix_blue;
            end
        end
    end

    // search engine
    logic [6:0] step, steps_total;
    logic [5:0] trial_phase, best_phase, next_trial;
    logic [8:0] step_x9;
    logic [31:0] acc, best_metric;
    logic tgt_worst, pace_slow, better, launch_ok;
    logic [11:0] de_min, de_max;
    assign step_x9 = {step[5:0] + 6'h01, 3'h0} + {3'h0, step[5:0] + 6'h01};
    assign next_trial = pace_slow ? step[5:0] + 6'h01 : step_x9[7:2];
    assign better = tgt_worst ? acc < best_metric : acc > best_metric;
    assign launch_ok = cmd_code == pac_pkg::CMD_APPLY_PHASE
        || cmd_code == pac_pkg::CMD_APPLY_WINDOW;
    always_ff @(posedge core_clk) begin
        if (eng_rst) begin
            state <= pac_pkg::ST_IDLE;
            phase_engine_busy <= 1'b0;
            step <= '0;
            steps_total <= pac_pkg::STEPS_FAST;
            trial_phase <= '0;
            best_phase <= '0;
            sample_phase <= '0;
            acc <= '0;
            best_metric <= '0;
            tgt_worst <= 1'b0;
            pace_slow <= 1'b0;
            de_min <= 12'hFFF;
            de_max <= '0;
            active_start <= '0;
            active_width <= '0;
        end else if (cmd_wr && launch_ok) begin
            phase_engine_busy <= 1'b1;
            state <= cmd_code == pac_pkg::CMD_APPLY_PHASE ? pac_pkg::ST_SRCH_ARM
                : pac_pkg::ST_DE_ARM;
        end else begin
            if (state == pac_pkg::ST_SRCH && coll && coll_d) begin
                acc <= acc + {20'h00000, pix_metric};
            end
            case (state)
                pac_pkg::ST_IDLE: phase_engine_busy <= 1'b0;
                pac_pkg::ST_SRCH_ARM: begin
                    if (frame_edge) begin
                        state <= pac_pkg::ST_SRCH;
                        step <= '0;
                        trial_phase <= '0;
                        sample_phase <= '0;
                        acc <= '0;
                        tgt_worst <= opt[pac_pkg::BIT_TARGET];
                        pace_slow <= opt[pac_pkg::BIT_PACE];
                        steps_total <= opt[pac_pkg::BIT_PACE] ? pac_pkg::STEPS_SLOW
                            : pac_pkg::STEPS_FAST;
                    end
                end
                pac_pkg::ST_SRCH: begin
                    if (frame_edge) begin
                        if (step == 7'h00 || better) begin
                            best_metric <= acc;
                            best_phase <= trial_phase;
                        end
                        acc <= '0;
                        if (step + 7'h01 == steps_total) begin
                            state <= pac_pkg::ST_APPLY;
                        end else begin
                            step <= step + 7'h01;
                            trial_phase <= next_trial;
                            sample_phase <= next_trial;
                        end
                    end
                end
                pac_pkg::ST_APPLY: begin
                    if (!opt[pac_pkg::BIT_DEFER] || frame_edge) begin
                        sample_phase <= best_phase;
                        state <= pac_pkg::ST_IDLE;
                        phase_engine_busy <= 1'b0;
                    end
                end
                pac_pkg::ST_DE_ARM: begin
                    if (frame_edge) begin
                        state <= pac_pkg::ST_DE_RUN;
                        de_min <= 12'hFFF;
                        de_max <= '0;
                    end
                end
                pac_pkg::ST_DE_RUN: begin
                    if (frame_edge) begin
                        active_start <= de_min;
                        active_width <= de_max >= de_min ? de_max - de_min + 12'h001 : 12'h000;
                        state <= pac_pkg::ST_IDLE;
                        phase_engine_busy <= 1'b0;
                    end else if (coll && active_px) begin
                        if (pix_cnt < de_min) de_min <= pix_cnt;
                        if (pix_cnt > de_max) de_max <= pix_cnt;
                    end
                end
                default: state <= pac_pkg::ST_IDLE;
            endcase
        end
    end

    // frame measurement
    logic [8:0] xdiv;
    logic [15:0] lx_cnt, lx_len, lt;
    logic xtal512, timed_line, unit_tick;
    logic [11:0] fp_cnt;
    logic [6:0] vw_cnt;
    assign xtal512 = xtal_tick && xdiv == pac_pkg::XTAL_DIV_LAST;
    assign timed_line = xtal_tick && lx_len != 16'h0000 && lt + 16'h0001 >= lx_len;
    assign unit_tick = meas_cfg[pac_pkg::BIT_UNITS] ? xtal512
        : (meas_cfg[pac_pkg::BIT_LCMODE] ? timed_line : line_sync_output);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            xdiv <= '0;
            lx_cnt <= '0;
            lx_len <= '0;
            lt <= '0;
        end else begin
            if (xtal_tick) xdiv <= xdiv + 9'h001;
            if (line_sync_output) begin
                lx_len <= lx_cnt;
                lx_cnt <= '0;
            end else if (xtal_tick && lx_cnt != 16'hFFFF) begin
                lx_cnt <= lx_cnt + 16'h0001;
            end
            if (frame_edge || timed_line) lt <= '0;
            else if (xtal_tick && lt != 16'hFFFF) lt <= lt + 16'h0001;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            fp_cnt <= '0;
            vw_cnt <= '0;
            frame_period <= '0;
            vsync_width <= '0;
        end else begin
            if (frame_edge) begin
                frame_period <= fp_cnt;
                fp_cnt <= {11'h000, unit_tick};
                vw_cnt <= {6'h00, unit_tick};
            end else begin
                if (unit_tick && fp_cnt != 12'hFFF) fp_cnt <= fp_cnt + 12'h001;
                if (frame_sync && unit_tick && vw_cnt != 7'h7F) vw_cnt <= vw_cnt + 7'h01;
            end
            if (!frame_sync && fs_d) vsync_width <= vw_cnt;
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (eng_rst);
    sequence s_phase_cmd;
        cmd_wr && cmd_code == pac_pkg::CMD_APPLY_PHASE;
    endsequence
    sequence s_armed;
        state == pac_pkg::ST_SRCH_ARM && phase_engine_busy;
    endsequence
    chk_phase_launch: assert property (s_phase_cmd |=> s_armed)
        else $error("phase command did not arm search");
    chk_busy_hold: assert property (cmd_wr && launch_ok |=> phase_engine_busy [*2])
        else $error("busy did not hold after launch");
    chk_reserved_cmd: assert property (state == pac_pkg::ST_IDLE
        && !phase_engine_busy && cmd_wr && !launch_ok |=> !phase_engine_busy)
        else $error("reserved command launched engine");
    chk_soft_reset: assert property (disable iff (srst)
        opt[pac_pkg::BIT_SOFT_RST] |=> state == pac_pkg::ST_IDLE && !phase_engine_busy)
        else $error("engine not held in soft reset");
    chk_status_read: assert property (disable iff (srst) s_axi_arvalid
        && s_axi_arready && rd_idx == pac_pkg::IDX_STATUS
        |=> s_axi_rdata[7] == $past(phase_engine_busy))
        else $error("status bit does not show busy");
    chk_vis_reset: assert property (disable iff (1'b0) srst
        |=> {visible_lines_high, visible_lines_low} == 12'h400)
        else $error("visible line count reset wrong");
    chk_pixel_mask: assert property (coll |-> {1'b0, pix_cnt}
        >= {4'h0, pixels_skip_after_line_edge, 1'b0}
        && {1'b0, pix_cnt} + {4'h0, pixels_skip_before_line_edge, 1'b0} < {1'b0, line_len})
        else $error("pixel collected inside mask");
    chk_line_mask: assert property (coll |-> line_cnt >= 12'h005
        && line_cnt + 12'h001 < frame_lines || lines_skip_after_frame_edge != 3'h0
        || lines_skip_before_frame_edge != 3'h1)
        else $error("line collected inside default mask");
    chk_all_off: assert property (opt[2:0] == 3'h7 |-> pix_metric == 12'h000)
        else $error("disabled channels still measured");
    chk_pace: assert property ($rose(state == pac_pkg::ST_SRCH)
        |-> steps_total == ($past(opt[pac_pkg::BIT_PACE]) ? 7'h40 : 7'h1C))
        else $error("wrong search step count");
    chk_defer_apply: assert property (state == pac_pkg::ST_APPLY
        && opt[pac_pkg::BIT_DEFER] && !frame_edge && !cmd_wr |=> state == pac_pkg::ST_APPLY)
        else $error("phase applied before frame edge");
    chk_unit_xtal: assert property (disable iff (srst)
        meas_cfg[pac_pkg::BIT_UNITS] && !frame_edge && !xtal512 |=> fp_cnt == $past(fp_cnt))
        else $error("frame period counted off unit");
endmodule
`default_nettype wire

// [verilog/pac_pkg.sv]
// package: register map, field positions and constants for phase adjust control
//
// Contract
// - 12-bit visible line count, resets to 0x400
// - config bit 0: lines or 512 crystal clocks
// - config bit 1: integer or timed line count
// - each command write decodes its low three bits; only 011 and 100 launch
// - 011 sets phase, 100 sets window; others reserved
// - status bit 7 shows engine busy
// - lines skipped before frame edge, table coded
// - lines skipped after frame edge, table coded
// - skip 2N pixels after line edge
// - skip 2N pixels before line edge
// - option bits 0-2 drop blue, green, red
// - option bit 3 seeks best or worst phase
// - option bit 4 picks 28 or 64 steps
// - option bit 5 defers phase to frame edge
// - option bit 6 holds engine in reset
// - unit applies to frame period and width
`default_nettype none
package pac_pkg;
    // register indices; byte address is four times the index
    localparam logic [6:0] IDX_VIS_HI = 7'h4D;
    localparam logic [6:0] IDX_VIS_LO = 7'h4E;
    localparam logic [6:0] IDX_MEAS = 7'h4F;
    localparam logic [6:0] IDX_CMD = 7'h50;
    localparam logic [6:0] IDX_STATUS = 7'h51;
    localparam logic [6:0] IDX_VMASK = 7'h52;
    localparam logic [6:0] IDX_HMASK1 = 7'h53;
    localparam logic [6:0] IDX_HMASK2 = 7'h54;
    localparam logic [6:0] IDX_OPT = 7'h55;
    // reset values
    localparam logic [3:0] RST_VIS_HI = 4'h4;
    localparam logic [7:0] RST_VIS_LO = 8'h00;
    localparam logic [1:0] RST_MEAS = 2'h0;
    localparam logic [2:0] RST_SKIP_BEFORE = 3'h1;
    localparam logic [2:0] RST_SKIP_AFTER = 3'h0;
    localparam logic [7:0] RST_HMASK1 = 8'h01;
    localparam logic [7:0] RST_HMASK2 = 8'h01;
    localparam logic [6:0] RST_OPT = 7'h20;
    // field positions
    localparam int BIT_UNITS = 0;
    localparam int BIT_LCMODE = 1;
    localparam int BIT_BUSY = 7;
    localparam int BIT_BLUE_OFF = 0;
    localparam int BIT_GREEN_OFF = 1;
    localparam int BIT_RED_OFF = 2;
    localparam int BIT_TARGET = 3;
    localparam int BIT_PACE = 4;
    localparam int BIT_DEFER = 5;
    localparam int BIT_SOFT_RST = 6;
    // commands and counts
    localparam logic [2:0] CMD_APPLY_PHASE = 3'h3;
    localparam logic [2:0] CMD_APPLY_WINDOW = 3'h4;
    localparam logic [6:0] STEPS_FAST = 7'h1C;
    localparam logic [6:0] STEPS_SLOW = 7'h40;
    localparam logic [8:0] XTAL_DIV_LAST = 9'h1FF;
    localparam logic [9:0] ACT_LEVEL = 10'h040;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SRCH_ARM = 6'h02,
        ST_SRCH = 6'h04,
        ST_APPLY = 6'h08,
        ST_DE_ARM = 6'h10,
        ST_DE_RUN = 6'h20
    } pac_state_t;

    function automatic logic [5:0] pac_lines_before(input logic [2:0] code);
        case (code)
            3'h0: pac_lines_before = 6'h00;
            3'h1: pac_lines_before = 6'h01;
            3'h2: pac_lines_before = 6'h02;
            3'h3: pac_lines_before = 6'h04;
            3'h4: pac_lines_before = 6'h06;
            3'h5: pac_lines_before = 6'h08;
            3'h6: pac_lines_before = 6'h0A;
            default: pac_lines_before = 6'h0C;
        endcase
    endfunction

    function automatic logic [5:0] pac_lines_after(input logic [2:0] code);
        case (code)
            3'h0: pac_lines_after = 6'h05;
            3'h1: pac_lines_after = 6'h12;
            3'h2: pac_lines_after = 6'h13;
            3'h3: pac_lines_after = 6'h14;
            3'h4: pac_lines_after = 6'h16;
            3'h5: pac_lines_after = 6'h19;
            3'h6: pac_lines_after = 6'h29;
            default: pac_lines_after = 6'h2C;
        endcase
    endfunction
endpackage
`default_nettype wire

// [test/auto_phase_adjust_control_test.sv]
// self-checking bench for the phase adjust control block
`default_nettype none
module auto_phase_adjust_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, line_sync_output = 0, frame_sync = 0;
    logic pixel_valid = 0, xtal_tick = 0, phase_engine_busy;
    logic [8:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF, visible_lines_high;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [9:0] pix_red = 0, pix_green = 0, pix_blue = 0;
    logic [5:0] sample_phase, last_phase;
    logic [11:0] active_start, active_width, frame_period, cnt = 0;
    logic [6:0] vsync_width;
    logic [7:0] visible_lines_low;
    int fails = 0, compares = 0;
    logic [26:0] rows [9];
    logic [16:0] rst_rows [7];
    pac_top uut (.*);
    always #2.5 core_clk = ~core_clk;
    // free-running video timing and pixel stimulus
    always @(posedge core_clk) begin
        cnt <= cnt + 12'h001;
        line_sync_output <= cnt[4:0] == 5'h00;
        frame_sync <= cnt[8:6] == 3'h0;
        xtal_tick <= cnt[0];
        pixel_valid <= cnt[4:0] > 5'h03;
        pix_red <= {cnt[3:0], 6'h00};
        pix_green <= {cnt[5:0], 4'h0};
        // blue swing grows with the sampling phase
        pix_blue <= cnt[0] ? {sample_phase, 4'h0} : 10'h000;
    end
    task automatic check(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        fork
            begin do @(posedge core_clk); while (s_axi_awready !== 1'h1); s_axi_awvalid <= 1'h0; end
            begin do @(posedge core_clk); while (s_axi_wready !== 1'h1); s_axi_wvalid <= 1'h0; end
        join
        while (s_axi_bvalid !== 1'h1) @(posedge core_clk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rdr(input logic [8:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge core_clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'h1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic tally_and_finish;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        rows = '{{9'h134, 8'h0A, 8'h0A, 2'h0}, {9'h138, 8'h5C, 8'h5C, 2'h0},
            {9'h13C, 8'h03, 8'h03, 2'h0}, {9'h148, 8'h75, 8'h75, 2'h0},
            {9'h14C, 8'h02, 8'h02, 2'h0}, {9'h150, 8'h03, 8'h03, 2'h0},
            {9'h154, 8'hAF, 8'h2F, 2'h0}, {9'h140, 8'h03, 8'h00, 2'h0},
            {9'h1FC, 8'h11, 8'h00, 2'h2}};
        rst_rows = '{{9'h134, 8'h04}, {9'h138, 8'h00}, {9'h13C, 8'h00}, {9'h148, 8'h01},
            {9'h14C, 8'h01}, {9'h150, 8'h01}, {9'h154, 8'h20}};
        repeat (4) @(posedge core_clk);
        srst <= 1'h0;
        repeat (2) @(posedge core_clk);
        foreach (rows[i]) begin
            wr(rows[i][26:18], rows[i][17:10]);
            check("bresp", rows[i][1:0], resp);
            rdr(rows[i][26:18]);
            check("rresp", rows[i][1:0], resp);
            check("rdata", rows[i][9:2], rd);
        end
        check("lines", 12'hA5C, {visible_lines_high, visible_lines_low});
        srst <= 1'h1;
        repeat (4) @(posedge core_clk);
        srst <= 1'h0;
        repeat (2) @(posedge core_clk);
        check("busy", 1'h0, phase_engine_busy);
        foreach (rst_rows[i]) begin
            rdr(rst_rows[i][16:8]);
            check("reset value", rst_rows[i][7:0], rd);
        end
        wr(9'h140, 8'h03);
        @(posedge core_clk);
        check("busy", 1'h1, phase_engine_busy);
        rdr(9'h144);
        check("status", 32'h80, rd);
        wr(9'h154, 8'h60);
        repeat (2) @(posedge core_clk);
        check("busy", 1'h0, phase_engine_busy);
        rdr(9'h144);
        check("status", 32'h00, rd);
        wr(9'h154, 8'h20);
        wr(9'h140, 8'h05);
        repeat (2) @(posedge core_clk);
        check("busy", 1'h0, phase_engine_busy);
        repeat (1100) @(posedge core_clk);
        wr(9'h140, 8'h04);
        @(posedge core_clk);
        check("busy", 1'h1, phase_engine_busy);
        while (phase_engine_busy !== 1'h0) @(posedge core_clk);
        check("active_start", 12'h002, active_start);
        check("active_width", 12'h018, active_width);
        wr(9'h154, 8'h28);
        wr(9'h140, 8'h03);
        while (phase_engine_busy !== 1'h0) begin
            last_phase = sample_phase;
            @(posedge core_clk);
        end
        check("last trial", 6'h3C, last_phase);
        check("sample_phase", 6'h00, sample_phase);
        check("frame_period", 12'h010, frame_period);
        check("vsync_width", 7'h02, vsync_width);
        tally_and_finish;
    end
    initial begin
        #300000;
        fails++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
